// >>> acs_pkg.sv
/*
 * shared constants of the conversion sequencer: register indices,
 * field positions, reset values, conversion time codes and bus answers.
 * assumes a 32-bit AXI4-Lite bus, one aligned word per register index.
 */
package acs_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0]  IDX_CTRL_ONE    = 8'h0e;
   localparam logic [7:0]  IDX_CTRL_TWO    = 8'h0f;
   localparam logic [7:0]  IDX_RESULT      = 8'h20;
   localparam logic [7:0]  IDX_STATUS      = 8'h21;
   // control one fields
   localparam int          START_BIT       = 7;
   localparam int          INPUT_EN_BIT    = 4;
   localparam int          SEL_LSB         = 0;
   // control two fields
   localparam int          LADDER_BIT      = 5;
   localparam int          TIME_LSB        = 1;
   // status fields
   localparam int          EOC_BIT         = 5;
   localparam int          BUSY_BIT        = 4;
   // reset values
   localparam logic [7:0]  CTRL_ONE_RST    = 8'h10;
   localparam logic [7:0]  CTRL_TWO_RST    = 8'h00;
   localparam logic [7:0]  RESULT_RST      = 8'h00;
   // channel select codes
   localparam logic [3:0]  SEL_CH_TWO      = 4'h2;
   localparam logic [3:0]  SEL_CH_THREE    = 4'h3;
   localparam logic [3:0]  SEL_CH_FOUR     = 4'h4;
   localparam logic [3:0]  SEL_CH_FIVE     = 4'h5;
   // conversion time codes and their clock counts
   localparam logic [2:0]  TIME_SHORT      = 3'h2;
   localparam logic [2:0]  TIME_MID        = 3'h3;
   localparam logic [2:0]  TIME_LONG       = 3'h4;
   localparam logic [8:0]  CYC_SHORT       = 9'h04e;
   localparam logic [8:0]  CYC_MID         = 9'h09c;
   localparam logic [8:0]  CYC_LONG        = 9'h138;
   // bus answers
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // sequencer states
   typedef enum logic [0:0] {
      ACS_IDLE       = 1'b0,
      ACS_CONVERTING = 1'b1
   } acs_state_t;
endpackage

// >>> acs_sequencer.sv
/*
 * conversion sequencer of an 8-bit successive-approximation converter,
 * with its control and result registers behind an AXI4-Lite slave.
 * assumes: CORE_CLK is the high-frequency clock, STOP_MODE comes from
 * logic on the same clock, channel samples arrive from the analog side
 * asynchronously and are synchronised here.
 */
// Functional notes
// - start bit launches conversion of selected channel
// - completion loads result, sets flag, interrupts
// - start bit clears itself, reads zero
// - result valid only after full conversion time
// - reading result clears end flag
// - restart clears flag, keeps old result
// - stop aborts conversion, resets both controls
// - stop discards held results
// - after stop, stay idle until restarted
// - stop disconnects the reference ladder
// - result is unsigned eight bits
// - channels two through five are selectable
// - start bit sits at bit seven
// - longest time equals 312 clock periods
// - busy flag follows conversion, clears on stop
// - controls ignore writes during stop
`timescale 1ns/1ns
module acs_sequencer #(
   parameter int ADDR_W = 12                 // bus address width
) (
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   input  wire logic              STOP_MODE,
   input  wire logic [7:0]        CH2_SAMPLE,
   input  wire logic [7:0]        CH3_SAMPLE,
   input  wire logic [7:0]        CH4_SAMPLE,
   input  wire logic [7:0]        CH5_SAMPLE,
   output logic                   LADDER_CONNECT,
   output logic                   CONVERSION_DONE_IRQ,
   output logic                   CONVERTER_BUSY,
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY
);

   // word index from a byte address; low two bits ignored
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[9:2];
   endfunction

   // true when the address falls on a mapped register
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      is_mapped = (a[ADDR_W-1:10] == '0) &&
                  (i == acs_pkg::IDX_CTRL_ONE || i == acs_pkg::IDX_CTRL_TWO ||
                   i == acs_pkg::IDX_RESULT   || i == acs_pkg::IDX_STATUS);
   endfunction

   logic             rst_meta_reg;        // reset release stage one
   logic             rst_n;               // released reset copy
   logic [7:0]       ch_meta_reg [4];     // sample sync stage one
   logic [7:0]       ch_sync_reg [4];     // sample sync stage two
   logic [7:0]       ctrl_one_reg;        // start bit never stored
   logic [7:0]       ctrl_two_reg;        // ladder and time code
   logic [7:0]       result_reg;          // last finished result
   logic             eoc_reg;             // end of conversion flag
   logic             irq_reg;             // done pulse
   logic             ladder_reg;          // ladder switch
   acs_pkg::acs_state_t state_reg;        // sequencer state
   logic [8:0]       cnt_reg;             // cycles still to run
   logic [7:0]       sample_sel;          // selected channel value
   logic [8:0]       conv_len;            // cycles for the time code
   logic             aw_held_reg;         // write address waiting
   logic [ADDR_W-1:0] aw_addr_reg;        // held write address
   logic             w_held_reg;          // write data waiting
   logic [7:0]       w_data_reg;          // held low data byte
   logic             w_lane_reg;          // low byte lane enabled
   logic             wr_commit;           // both halves present
   logic             wr_ok;               // commit may change state
   logic             start_req;           // launch this cycle
   logic             done_pulse;          // completion this cycle
   logic             ar_fire;             // read address taken
   logic             rd_clear;            // result read side effect
   logic [31:0]      rd_word;             // read mux output

   // reset released through two flops, asserted at once
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // samples come from the analog side, two flops before use
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 4; i++)
         begin
            ch_meta_reg[i] <= 8'h00;
            ch_sync_reg[i] <= 8'h00;
         end
      end
      else
      begin
         ch_meta_reg[0] <= CH2_SAMPLE;
         ch_meta_reg[1] <= CH3_SAMPLE;
         ch_meta_reg[2] <= CH4_SAMPLE;
         ch_meta_reg[3] <= CH5_SAMPLE;
         for (int i = 0; i < 4; i++)
            ch_sync_reg[i] <= ch_meta_reg[i];
      end
   end

   // channel mux; reserved codes or a disabled input give zero
   // channels two-five
   always_comb
   begin
      sample_sel = 8'h00;
      if (!ctrl_one_reg[acs_pkg::INPUT_EN_BIT])
      begin
         unique case (ctrl_one_reg[acs_pkg::SEL_LSB +: 4])
            acs_pkg::SEL_CH_TWO:   sample_sel = ch_sync_reg[0];
            acs_pkg::SEL_CH_THREE: sample_sel = ch_sync_reg[1];
            acs_pkg::SEL_CH_FOUR:  sample_sel = ch_sync_reg[2];
            acs_pkg::SEL_CH_FIVE:  sample_sel = ch_sync_reg[3];
            default:               sample_sel = 8'h00;
         endcase
      end
   end

   // time code to cycle count; reserved codes run the longest time
   // time code decode
   always_comb
   begin
      unique case (ctrl_two_reg[acs_pkg::TIME_LSB +: 3])
         acs_pkg::TIME_SHORT: conv_len = acs_pkg::CYC_SHORT;
         acs_pkg::TIME_MID:   conv_len = acs_pkg::CYC_MID;
         default:             conv_len = acs_pkg::CYC_LONG;
      endcase
   end

   // bus handshakes: one write and one read in flight
   assign AWREADY    = !aw_held_reg && !BVALID;
   assign WREADY     = !w_held_reg && !BVALID;
   assign ARREADY    = !RVALID;
   assign ar_fire    = ARVALID && ARREADY;
   assign wr_commit  = aw_held_reg && w_held_reg;
   assign wr_ok      = wr_commit && is_mapped(aw_addr_reg) && w_lane_reg
                       && !STOP_MODE;
   assign start_req  = wr_ok && word_idx(aw_addr_reg) == acs_pkg::IDX_CTRL_ONE
                       && w_data_reg[acs_pkg::START_BIT]
                       && state_reg == acs_pkg::ACS_IDLE;
   assign done_pulse = state_reg == acs_pkg::ACS_CONVERTING && cnt_reg == 9'h000
                       && !STOP_MODE;
   assign rd_clear   = ar_fire && is_mapped(ARADDR)
                       && word_idx(ARADDR) == acs_pkg::IDX_RESULT;

   // write address and data captured in either order
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
         BVALID      <= 1'b0;
         BRESP       <= acs_pkg::RESP_OKAY;
      end
      else
      begin
         if (AWVALID && AWREADY)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
         end
         if (WVALID && WREADY)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA[7:0];
            w_lane_reg <= WSTRB[0];
         end
         // answer one edge after both halves are held
         if (wr_commit)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            BVALID      <= 1'b1;
            BRESP       <= is_mapped(aw_addr_reg) ? acs_pkg::RESP_OKAY
                                                  : acs_pkg::RESP_SLVERR;
         end
         else if (BREADY)
            BVALID <= 1'b0;
      end
   end

   // read word assembly; reserved bits read zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      unique case (word_idx(ARADDR))
         acs_pkg::IDX_CTRL_ONE: rd_word[7:0] = ctrl_one_reg;
         acs_pkg::IDX_CTRL_TWO: rd_word[5:0] = ctrl_two_reg[5:0];
         acs_pkg::IDX_RESULT:   rd_word[7:0] = result_reg;
         acs_pkg::IDX_STATUS:
         begin
            rd_word[acs_pkg::EOC_BIT]  = eoc_reg;
            rd_word[acs_pkg::BUSY_BIT] = CONVERTER_BUSY;
         end
         default:               rd_word = 32'h0000_0000;
      endcase
   end

   // read answer one edge after the address is taken
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0000_0000;
         RRESP  <= acs_pkg::RESP_OKAY;
      end
      else if (ar_fire)
      begin
         RVALID <= 1'b1;
         RDATA  <= is_mapped(ARADDR) ? rd_word : 32'h0000_0000;
         RRESP  <= is_mapped(ARADDR) ? acs_pkg::RESP_OKAY
                                     : acs_pkg::RESP_SLVERR;
      end
      else if (RREADY)
         RVALID <= 1'b0;
   end

   // control registers; the start bit is a strobe, never stored
   // stop resets controls
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_one_reg <= acs_pkg::CTRL_ONE_RST;
         ctrl_two_reg <= acs_pkg::CTRL_TWO_RST;
      end
      else if (STOP_MODE)
      begin
         ctrl_one_reg <= acs_pkg::CTRL_ONE_RST;
         ctrl_two_reg <= acs_pkg::CTRL_TWO_RST;
      end
      else if (wr_ok)
      begin
         if (word_idx(aw_addr_reg) == acs_pkg::IDX_CTRL_ONE)
            ctrl_one_reg <= {1'b0, w_data_reg[6:0]};
         if (word_idx(aw_addr_reg) == acs_pkg::IDX_CTRL_TWO)
            ctrl_two_reg <= {2'b00, w_data_reg[5:0]};
      end
   end

   // sequencer; a restart while busy is dropped, software must wait
   // full time counted
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= acs_pkg::ACS_IDLE;
         cnt_reg   <= 9'h000;
      end
      else if (STOP_MODE)
      begin
         state_reg <= acs_pkg::ACS_IDLE;
         cnt_reg   <= 9'h000;
      end
      else if (start_req)
      begin
         state_reg <= acs_pkg::ACS_CONVERTING;
         cnt_reg   <= conv_len - 9'h001;
      end
      else if (done_pulse)
         state_reg <= acs_pkg::ACS_IDLE;
      else if (state_reg == acs_pkg::ACS_CONVERTING)
         cnt_reg <= cnt_reg - 9'h001;
   end

   // result, flag and interrupt move on the same edge
   // load, flag, interrupt
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_reg <= acs_pkg::RESULT_RST;
         irq_reg    <= 1'b0;
      end
      else
      begin
         irq_reg <= done_pulse;
         if (STOP_MODE)
            result_reg <= acs_pkg::RESULT_RST;
         else if (done_pulse)
            result_reg <= sample_sel;
      end
   end

   // end flag: completion wins over a read or restart in that cycle
   // restart clears flag
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
         eoc_reg <= 1'b0;
      else if (STOP_MODE)
         eoc_reg <= 1'b0;
      else if (done_pulse)
         eoc_reg <= 1'b1;
      else if (start_req || rd_clear)
         eoc_reg <= 1'b0;
   end

   // ladder on while converting or forced on by software
   // stop disconnects ladder
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
         ladder_reg <= 1'b0;
      else
         ladder_reg <= !STOP_MODE && (ctrl_two_reg[acs_pkg::LADDER_BIT]
                       || start_req || (state_reg ==
                       acs_pkg::ACS_CONVERTING && !done_pulse));
   end

   assign CONVERTER_BUSY      = state_reg == acs_pkg::ACS_CONVERTING;
   assign CONVERSION_DONE_IRQ = irq_reg;
   assign LADDER_CONNECT      = ladder_reg;

   // helper: cycles since launch, only the checks read it
   logic [8:0] elapsed_reg;
   logic [8:0] len_reg;
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         elapsed_reg <= 9'h000;
         len_reg     <= 9'h000;
      end
      else if (start_req)
      begin
         elapsed_reg <= 9'h001;
         len_reg     <= conv_len;
      end
      else
         elapsed_reg <= elapsed_reg + 9'h001;
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!rst_n);

   sequence s_launch;
      start_req ##1 CONVERTER_BUSY;
   endsequence
   sequence s_finish;
      done_pulse ##1 (eoc_reg && irq_reg && !CONVERTER_BUSY);
   endsequence

   AST_START_BUSY: assert property (start_req |-> s_launch)
      else $error("start did not raise busy");
   AST_DONE_LOAD: assert property (done_pulse |-> s_finish ##0
      (result_reg == $past(sample_sel)))
      else $error("completion did not load result and flag");
   AST_START_ZERO: assert property (ar_fire && is_mapped(ARADDR) &&
      word_idx(ARADDR) == acs_pkg::IDX_CTRL_ONE |=> !RDATA[7])
      else $error("start bit read back as one");
   AST_CONV_TIME: assert property (done_pulse |->
      elapsed_reg == len_reg)
      else $error("conversion time not respected");
   AST_READ_CLEAR: assert property (rd_clear && !done_pulse
      && !STOP_MODE |=> !eoc_reg)
      else $error("result read did not clear flag");
   AST_KEEP_OLD: assert property (start_req |=>
      (!eoc_reg && $stable(result_reg)))
      else $error("restart lost old result");
   AST_STOP_INIT: assert property (STOP_MODE |=>
      (ctrl_one_reg == acs_pkg::CTRL_ONE_RST &&
       ctrl_two_reg == acs_pkg::CTRL_TWO_RST &&
       result_reg == acs_pkg::RESULT_RST && !eoc_reg && !CONVERTER_BUSY))
      else $error("stop did not initialise converter");
   AST_STOP_LADDER: assert property (STOP_MODE |=> !LADDER_CONNECT)
      else $error("ladder still connected in stop");
   AST_NO_RESUME: assert property (!CONVERTER_BUSY && !start_req
      |=> !CONVERTER_BUSY)
      else $error("conversion resumed on its own");
   AST_IRQ_ONCE: assert property (irq_reg |=> !irq_reg)
      else $error("interrupt longer than one cycle");

endmodule // acs_sequencer

// >>> acs_sequencer_test.sv
/*
 * self-checking bench of the conversion sequencer: register bus tasks,
 * conversions over every time code, channels two to four and a disabled five, restart, stop abort.
 * assumes the sequencer's own assertions sit in its body.
 */
`timescale 1ns/1ns
module acs_sequencer_test;
   localparam logic [11:0] A_ONE  = 12'h038;   // control one
   localparam logic [11:0] A_TWO  = 12'h03c;   // control two
   localparam logic [11:0] A_RES  = 12'h080;   // result
   localparam logic [11:0] A_STAT = 12'h084;   // status
   localparam logic [1:0]  OK     = acs_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR    = acs_pkg::RESP_SLVERR;

   logic        core_clk, rst_n, stop_mode, ladder, irq, busy;
   logic [7:0]  smp [2:5];                     // channel samples
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          fail_count, checked, busy_cnt, irq_cnt;
   logic [3:0]  strb_sel;                      // write lane enables
   logic [31:0] seed;                          // random state

   acs_sequencer acs_sequencer_inst (
      .CORE_CLK(core_clk), .RST_N(rst_n), .STOP_MODE(stop_mode),
      .CH2_SAMPLE(smp[2]), .CH3_SAMPLE(smp[3]), .CH4_SAMPLE(smp[4]),
      .CH5_SAMPLE(smp[5]), .LADDER_CONNECT(ladder),
      .CONVERSION_DONE_IRQ(irq), .CONVERTER_BUSY(busy),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

   // free running clock, 50 ns period
   always #25 core_clk = ~core_clk;

   // counted on the falling edge so main flow never races the count
   always @(negedge core_clk)
   begin
      busy_cnt += int'(busy === 1'b1);
      irq_cnt  += int'(irq === 1'b1);
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected conversion length; reserved codes run the long time
   function automatic int ncyc(input logic [2:0] code);
      case (code)
         3'h2:    return 78;
         3'h3:    return 156;
         default: return 312;
      endcase
   endfunction

   // disabled input or channel outside two..five gives zero
   function automatic logic [7:0] exp_res(input logic [3:0] ch,
                                          input logic dis);
      if (dis || ch < 4'h2 || ch > 4'h5)
         return 8'h00;
      return smp[ch];
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one write; address and data offered together, released when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int   k;
      logic done;
      logic [1:0] r;
      @(posedge core_clk);
      awaddr  <= a;
      wdata   <= {24'h00_0000, d};
      wstrb   <= strb_sel;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      done = 1'b0;
      r = 2'h3;
      for (k = 0; k < 1000 && !done; k++)
      begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      chk("write response", 32'(er), 32'(r));
   endtask

   // one read, compared under a mask, response compared too
   task automatic chk_rd(input string what, input logic [11:0] a,
                         input logic [7:0] exp, input logic [7:0] m,
                         input logic [1:0] er);
      int   k;
      logic done;
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      done = 1'b0;
      d = 32'hffff_ffff;
      r = 2'h3;
      for (k = 0; k < 1000 && !done; k++)
      begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      chk(what, {24'h00_0000, exp & m}, d & {24'hff_ffff, m});
      chk("read response", 32'(er), 32'(r));
   endtask

   // fresh random samples on all four channels
   task automatic new_samples();
      for (int j = 2; j <= 5; j++)
      begin
         seed = lfsr(seed);
         smp[j] <= seed[7:0];
      end
   endtask

   // program both controls in order, then launch
   task automatic start_conv(input logic [3:0] ch, input logic [2:0] code,
                             input logic dis, input logic lad);
      wr(A_ONE, {3'b001, dis, ch}, OK);                // control one
      wr(A_TWO, {2'b00, lad, 1'b1, code, 1'b0}, OK);   // control two
      busy_cnt = 0;
      irq_cnt = 0;
      wr(A_ONE, {3'b101, dis, ch}, OK);                // launch
      chk_rd("start bit", A_ONE, {3'b001, dis, ch}, 8'hff, OK);
      chk_rd("busy", A_STAT, 8'h10, 8'h30, OK);
   endtask

   // wait for the interrupt, then check length, pulse and flag
   task automatic finish_conv(input int n);
      for (int k = 0; k < 1000 && irq_cnt == 0; k++)
         @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      chk("busy cycles", 32'(n), 32'(busy_cnt));
      chk("irq pulses", 32'd1, 32'(irq_cnt));
      chk_rd("end flag", A_STAT, 8'h20, 8'h30, OK);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // watchdog: the whole run needs a few thousand cycles
   initial
   begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      $display("mismatch watchdog expected finish seen timeout");
      conclude();
   end

   initial
   begin
      logic [2:0] codes [6];
      logic [3:0] ch;
      logic [7:0] old;
      logic       dis;
      codes = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h4, 3'h2};
      core_clk = 1'b0;
      rst_n = 1'b0;
      stop_mode = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      for (int j = 2; j <= 5; j++)
         smp[j] = 8'h00;
      fail_count = 0;
      checked = 0;
      busy_cnt = 0;
      irq_cnt = 0;
      seed = 32'h0001_2199;
      strb_sel = 4'h1;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      // reset values and an unmapped place
      chk_rd("ctrl one reset", A_ONE, 8'h10, 8'hff, OK);
      chk_rd("ctrl two reset", A_TWO, 8'h00, 8'hff, OK);
      chk_rd("result reset", A_RES, 8'h00, 8'hff, OK);
      chk_rd("status reset", A_STAT, 8'h00, 8'h30, OK);
      chk_rd("unmapped", 12'h040, 8'h00, 8'hff, ERR);
      wr(12'h040, 8'h55, ERR);
      // a write with its low lane off changes nothing
      strb_sel = 4'h0;
      wr(A_TWO, 8'h3f, OK);
      strb_sel = 4'h1;
      chk_rd("lane off", A_TWO, 8'h00, 8'hff, OK);
      // every time code, channels two to four, one disabled input on channel five
      for (int i = 0; i < 6; i++)
      begin
         new_samples();
         // last pass uses a reserved channel code, result zero
         ch = (i == 5) ? 4'h9 : 4'(2 + i % 4);
         dis = (i == 3);
         start_conv(ch, codes[i], dis, 1'b0);
         chk("ladder on", 32'd1, 32'(ladder));
         finish_conv(ncyc(codes[i]));
         chk_rd("result", A_RES, exp_res(ch, dis), 8'hff, OK);
         chk_rd("flag cleared", A_STAT, 8'h00, 8'h30, OK);
      end
      // restart before reading keeps the old result
      start_conv(4'h3, 3'h2, 1'b0, 1'b0);
      finish_conv(78);
      old = exp_res(4'h3, 1'b0);
      new_samples();
      start_conv(4'h4, 3'h2, 1'b0, 1'b0);
      chk_rd("old result", A_RES, old, 8'hff, OK);
      finish_conv(78);
      chk_rd("new result", A_RES, exp_res(4'h4, 1'b0), 8'hff, OK);
      // stop in mid conversion with the ladder forced on
      start_conv(4'h5, 3'h4, 1'b0, 1'b1);
      repeat (20) @(posedge core_clk);
      stop_mode <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("busy at stop", 32'd0, 32'(busy));
      chk("ladder at stop", 32'd0, 32'(ladder));
      wr(A_ONE, 8'ha3, OK);                            // ignored
      wr(A_TWO, 8'h38, OK);                            // ignored
      chk_rd("ctrl one stop", A_ONE, 8'h10, 8'hff, OK);
      chk_rd("ctrl two stop", A_TWO, 8'h00, 8'hff, OK);
      stop_mode <= 1'b0;
      irq_cnt = 0;
      chk_rd("result dropped", A_RES, 8'h00, 8'hff, OK);
      chk_rd("status stop", A_STAT, 8'h00, 8'h30, OK);
      repeat (400) @(posedge core_clk);
      chk("no resume irq", 32'd0, 32'(irq_cnt));
      chk("no resume busy", 32'd0, 32'(busy));
      chk("ladder idle", 32'd0, 32'(ladder));
      conclude();
   end
endmodule // acs_sequencer_test
